// ==== autoneg_regs_pkg.sv ====
// package: register map, field positions, reset values and carriers for the autoneg/gigabit register group
package autoneg_regs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_PARTNER_BASE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EXPANSION = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_NP_TRANSMIT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_NP_RECEIVE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_GIG_CONTROL = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_GIG_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_NP_EVENTS = 8'h2C;
    localparam int IDX_PARTNER_BASE = 5;
    localparam int IDX_EXPANSION = 6;
    localparam int IDX_NP_TRANSMIT = 7;
    localparam int IDX_NP_RECEIVE = 8;
    localparam int IDX_GIG_CONTROL = 9;
    localparam int IDX_GIG_STATUS = 10;
    localparam int EXP_PD_FAULT = 4;
    localparam int EXP_PARTNER_NP = 3;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_PARTNER_AN = 0;
    localparam int NPT_MORE = 15;
    localparam int NPT_MSG = 13;
    localparam int NPT_ACK2 = 12;
    localparam int NPT_TOGGLE = 11;
    localparam logic [15:0] NPT_WRITE_MASK = 16'hB7FF;
    localparam logic [15:0] NPT_RESET = 16'h2001;
    localparam logic [15:0] GCTL_WRITE_MASK = 16'hFFFF;
    localparam logic [15:0] GCTL_RESET = 16'h0700;
    localparam int GCTL_MS_MANUAL = 12;
    localparam int GCTL_MS_VALUE = 11;
    localparam int GST_MS_FAULT = 15;
    localparam int GST_MS_RESOLVE = 14;
    localparam int GST_LOCAL_RX = 13;
    localparam int GST_REMOTE_RX = 12;
    localparam int GST_PARTNER_FDX = 11;
    localparam int GST_PARTNER_HDX = 10;
    localparam logic [2:0] TM_NORMAL = 3'h0;
    localparam logic [2:0] TM_WAVEFORM = 3'h1;
    localparam logic [2:0] TM_JITTER_MASTER = 3'h2;
    localparam logic [2:0] TM_JITTER_SLAVE = 3'h3;
    localparam logic [2:0] TM_DISTORTION = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] IDLE_ERR_MAX = 8'hFF;

    // events and live levels from the negotiation engine
    typedef struct packed {
        logic basePageValid;
        logic [15:0] basePage;
        logic nextPageValid;
        logic [15:0] nextPage;
        logic parallelFault;
        logic partnerAnCapable;
        logic msFault;
        logic msResolvedValid;
        logic msResolvedMaster;
        logic localRxOk;
        logic remoteRxOk;
        logic partnerGigValid;
        logic partnerGigFdx;
        logic partnerGigHdx;
        logic idleError;
        logic pageSent;
        logic linkDown;
    } engine_status_t;

    // settings handed to the negotiation engine
    typedef struct packed {
        logic [15:0] nextPageWord;
        logic nextPageLoaded;
        logic [2:0] testMode;
        logic forceMs;
        logic forceMaster;
        logic portMulti;
        logic advGigFdx;
        logic advGigHdx;
    } engine_control_t;
endpackage

// ==== autoneg_gigabit_status_regs.sv ====
// autoneg partner, expansion, next-page and gigabit control/status registers behind AXI4-Lite
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// What this block does
// - partner base page register read-only, bits 15..0 as received from partner
// - partner base page reads zero after reset until a page arrives
// - parallel detection fault bit 4 latches high until expansion is read
// - page received bit 1 sets on a new page, clears when read
// - expansion bit3 partner np, bit2 local np one, bit0 partner an, rest zero
// - next page transmit word writable except bits 14 and 11; bit13 and code reset to one
// - toggle bit 11 is inverse of the previously transmitted toggle
// - partner next page receive register read-only, zero after reset
// - test mode field bits 15:13, codes 101 to 111 reserved
// - master/slave value bit 11 only acts while manual bit 12 set
// - gigabit fdx/hdx advertise bits and port type reset to one
// - master/slave fault bit 15 latches high until status is read
// - resolution bit 14: one master, zero slave, resets to one
// - resolution keeps the initial outcome, ignores later timing swaps
// - bit 13 local receiver ok, bit 12 remote receiver ok, live
// - bits 11,10 partner gigabit abilities, bits 9:8 zero
module autoneg_gigabit_status_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [autoneg_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [autoneg_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire autoneg_regs_pkg::engine_status_t engineStatus,
    output autoneg_regs_pkg::engine_control_t engineControl
);
    import autoneg_regs_pkg::*;

    logic [15:0] partnerBase;
    logic [15:0] partnerNext;
    logic [15:0] npTransmit;
    logic [15:0] gigControl;
    logic pdFault;
    logic pageRx;
    logic partnerNp;
    logic partnerAn;
    logic msFault;
    logic msMaster;
    logic msResolved;
    logic localRx;
    logic remoteRx;
    logic partnerFdx;
    logic partnerHdx;
    logic [7:0] idleCount;
    logic lastToggle;
    logic npLoaded;

    // write channel holding registers
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic doRead;
    logic [ADDR_W-1:0] rdAddr;
    logic readExp;
    logic readStat;
    logic [15:0] next_npTransmit;
    logic [15:0] next_gigControl;
    logic [15:0] readWord;
    logic readHit;
    logic writeHit;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign rdAddr = s_axi_araddr;
    assign readExp = doRead && (rdAddr == OFS_EXPANSION);
    assign readStat = doRead && (rdAddr == OFS_GIG_STATUS);

    // write address side, taken in either order with the data
    always_ff @(posedge clock) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            awAddr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
            end
        end
    end

    // write data side
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    assign writeHit = (awAddr == OFS_NP_TRANSMIT) || (awAddr == OFS_GIG_CONTROL);

    // write response stands until bready
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // byte-lane merge of writable bits
    always_comb begin
        next_npTransmit = npTransmit;
        next_gigControl = gigControl;
        for (int b = 0; b < 2; b++) begin
            if (wStrb[b]) begin
                next_npTransmit[b*8 +: 8] = (npTransmit[b*8 +: 8] & ~NPT_WRITE_MASK[b*8 +: 8])
                    | (wData[b*8 +: 8] & NPT_WRITE_MASK[b*8 +: 8]);
                next_gigControl[b*8 +: 8] = (gigControl[b*8 +: 8] & ~GCTL_WRITE_MASK[b*8 +: 8])
                    | (wData[b*8 +: 8] & GCTL_WRITE_MASK[b*8 +: 8]);
            end
        end
    end

    // outgoing next page, ack2 and code from software, toggle held by hardware
    always_ff @(posedge clock) begin
        if (!rstn) begin
            npTransmit <= NPT_RESET;
        end else if (doWrite && awAddr == OFS_NP_TRANSMIT) begin
            npTransmit <= next_npTransmit;
        end
    end

    // a written page stays loaded until the engine has sent it
    always_ff @(posedge clock) begin
        if (!rstn) begin
            npLoaded <= 1'b0;
        end else if (doWrite && awAddr == OFS_NP_TRANSMIT) begin
            npLoaded <= 1'b1;
        end else if (engineStatus.pageSent) begin
            npLoaded <= 1'b0;
        end
    end

    // toggle tracks the last transmitted link_code_word
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lastToggle <= 1'b1;
        end else if (engineStatus.linkDown) begin
            lastToggle <= 1'b1;
        end else if (engineStatus.pageSent) begin
            lastToggle <= ~lastToggle;
        end
    end

    // gigabit control, every bit writable
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gigControl <= GCTL_RESET;
        end else if (doWrite && awAddr == OFS_GIG_CONTROL) begin
            gigControl <= next_gigControl;
        end
    end

    // partner pages captured from the engine
    always_ff @(posedge clock) begin
        if (!rstn) begin
            partnerBase <= '0;
            partnerNp <= 1'b0;
        end else if (engineStatus.basePageValid) begin
            partnerBase <= engineStatus.basePage;
            partnerNp <= engineStatus.basePage[15];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            partnerNext <= '0;
        end else if (engineStatus.nextPageValid) begin
            partnerNext <= engineStatus.nextPage;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            partnerAn <= 1'b0;
        end else begin
            partnerAn <= engineStatus.partnerAnCapable;
        end
    end

    // expansion latches: set wins over read clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pdFault <= 1'b0;
        end else if (engineStatus.parallelFault) begin
            pdFault <= 1'b1;
        end else if (readExp) begin
            pdFault <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pageRx <= 1'b0;
        end else if (engineStatus.basePageValid || engineStatus.nextPageValid) begin
            pageRx <= 1'b1;
        end else if (readExp) begin
            pageRx <= 1'b0;
        end
    end

    // master/slave fault latch: set wins over read clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            msFault <= 1'b0;
        end else if (engineStatus.msFault) begin
            msFault <= 1'b1;
        end else if (readStat) begin
            msFault <= 1'b0;
        end
    end

    // first resolution of a link is kept, a later timing swap is ignored
    always_ff @(posedge clock) begin
        if (!rstn) begin
            msMaster <= 1'b1;
            msResolved <= 1'b0;
        end else if (engineStatus.linkDown) begin
            msResolved <= 1'b0;
        end else if (engineStatus.msResolvedValid && !msResolved) begin
            msMaster <= engineStatus.msResolvedMaster;
            msResolved <= 1'b1;
        end
    end

    // receiver status bits follow the engine's live levels
    always_ff @(posedge clock) begin
        if (!rstn) begin
            localRx <= 1'b0;
            remoteRx <= 1'b0;
        end else begin
            localRx <= engineStatus.localRxOk;
            remoteRx <= engineStatus.remoteRxOk;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            partnerFdx <= 1'b0;
            partnerHdx <= 1'b0;
        end else if (engineStatus.partnerGigValid) begin
            partnerFdx <= engineStatus.partnerGigFdx;
            partnerHdx <= engineStatus.partnerGigHdx;
        end
    end

    // idle error counter saturates, clears on read, new error after read counts one
    always_ff @(posedge clock) begin
        if (!rstn) begin
            idleCount <= '0;
        end else if (readStat) begin
            idleCount <= engineStatus.idleError ? 8'h01 : 8'h00;
        end else if (engineStatus.idleError && idleCount != IDLE_ERR_MAX) begin
            idleCount <= idleCount + 8'h01;
        end
    end

    // read mux
    always_comb begin
        readWord = 16'h0000;
        readHit = 1'b1;
        case (rdAddr)
            OFS_PARTNER_BASE: readWord = partnerBase;
            OFS_EXPANSION: begin
                readWord[EXP_PD_FAULT] = pdFault;
                readWord[EXP_PARTNER_NP] = partnerNp;
                readWord[EXP_LOCAL_NP] = 1'b1;
                readWord[EXP_PAGE_RX] = pageRx;
                readWord[EXP_PARTNER_AN] = partnerAn;
            end
            OFS_NP_TRANSMIT: begin
                readWord = npTransmit;
                readWord[NPT_TOGGLE] = ~lastToggle;
            end
            OFS_NP_RECEIVE: readWord = partnerNext;
            OFS_GIG_CONTROL: readWord = gigControl;
            OFS_GIG_STATUS: begin
                readWord[GST_MS_FAULT] = msFault;
                readWord[GST_MS_RESOLVE] = msMaster;
                readWord[GST_LOCAL_RX] = localRx;
                readWord[GST_REMOTE_RX] = remoteRx;
                readWord[GST_PARTNER_FDX] = partnerFdx;
                readWord[GST_PARTNER_HDX] = partnerHdx;
                readWord[7:0] = idleCount;
            end
            default: readHit = 1'b0;
        endcase
    end

    // read address offered only while no read data is pending
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
        end else if (doRead) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        end
    end

    // read data stands until rready
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, readWord};
            s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // settings to the engine, registered
    always_ff @(posedge clock) begin
        if (!rstn) begin
            engineControl <= '0;
        end else begin
            engineControl.nextPageWord <= {npTransmit[15:12], ~lastToggle, npTransmit[10:0]};
            engineControl.nextPageLoaded <= npLoaded;
            // reserved codes run as normal operation; media sense is software's duty
            engineControl.testMode <= (gigControl[15:13] > TM_DISTORTION) ? TM_NORMAL : gigControl[15:13];
            engineControl.forceMs <= gigControl[GCTL_MS_MANUAL];
            engineControl.forceMaster <= gigControl[GCTL_MS_MANUAL] & gigControl[GCTL_MS_VALUE];
            engineControl.portMulti <= gigControl[10];
            engineControl.advGigFdx <= gigControl[9];
            engineControl.advGigHdx <= gigControl[8];
        end
    end
endmodule

// ==== autoneg_regs_assertions.sv ====
// checker: bus timing and register content assertions for the autoneg register group
`timescale 1ns/10ps
module autoneg_regs_assertions (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [autoneg_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire autoneg_regs_pkg::engine_status_t engineStatus,
    input wire autoneg_regs_pkg::engine_control_t engineControl
);
    import autoneg_regs_pkg::*;
    logic [ADDR_W-1:0] lastAddr;
    logic pdSeen, pdAtAr, msSeen, msAtAr;
    wire arTake = s_axi_arvalid && s_axi_arready;
    // address and latched-flag copies taken when a read address is accepted
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lastAddr <= '0;
            pdAtAr <= 1'b0;
            msAtAr <= 1'b0;
        end else if (arTake) begin
            lastAddr <= s_axi_araddr;
            pdAtAr <= pdSeen;
            msAtAr <= msSeen;
        end
    end
    // expected latched flags: an event wins over the read that clears them
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pdSeen <= 1'b0;
            msSeen <= 1'b0;
        end else begin
            pdSeen <= engineStatus.parallelFault || (pdSeen && !(arTake && s_axi_araddr == OFS_EXPANSION));
            msSeen <= engineStatus.msFault || (msSeen && !(arTake && s_axi_araddr == OFS_GIG_STATUS));
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence arTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence readBack;
        s_axi_rvalid && s_axi_rresp == RESP_OKAY;
    endsequence
    read_answer_a: assert property (arTaken |=> s_axi_rvalid)
        else $error("read data not returned one cycle after address");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    no_ar_pending_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while a response is pending");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    exp_fixed_a: assert property (readBack ##0 lastAddr == OFS_EXPANSION |-> s_axi_rdata[15:5] == 11'h000 && s_axi_rdata[2])
        else $error("expansion fixed bits wrong");
    pd_latch_a: assert property (readBack ##0 lastAddr == OFS_EXPANSION |-> s_axi_rdata[4] == pdAtAr)
        else $error("parallel fault flag not latched until read");
    ms_latch_a: assert property (readBack ##0 lastAddr == OFS_GIG_STATUS |-> s_axi_rdata[15] == msAtAr)
        else $error("master slave fault flag not latched until read");
    gst_reserved_a: assert property (readBack ##0 lastAddr == OFS_GIG_STATUS |-> s_axi_rdata[9:8] == 2'h0)
        else $error("gigabit status reserved bits not zero");
    test_mode_a: assert property (engineControl.testMode <= TM_DISTORTION)
        else $error("reserved test mode passed to engine");
endmodule
bind autoneg_gigabit_status_regs autoneg_regs_assertions chk (.clock(clock), .rstn(rstn), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .engineStatus(engineStatus), .engineControl(engineControl));

// ==== engine_model.sv ====
// engine model: stands in for the negotiation engine and the remote partner behind it
`timescale 1ns/10ps
module engine_model (
    input wire logic clock,
    input wire autoneg_regs_pkg::engine_control_t engineControl,
    output autoneg_regs_pkg::engine_status_t engineStatus
);
    import autoneg_regs_pkg::*;
    engine_status_t levels;
    logic [15:0] lastSent;
    initial begin
        levels = '0;
        lastSent = '0;
        engineStatus = '0;
    end
    // live receiver and capability levels
    task automatic hold(input engine_status_t lv);
        levels = lv;
    endtask
    // one-cycle event; pages carry partner words, a repeated resolution models a timing swap
    task automatic fire(input engine_status_t ev);
        engine_status_t idle;
        idle = levels;
        idle.basePage = ~ev.basePage;
        idle.nextPage = ~ev.nextPage;
        @(posedge clock);
        engineStatus <= ev | levels;
        if (ev.pageSent) lastSent = engineControl.nextPageWord;
        @(posedge clock);
        engineStatus <= idle;
    endtask
endmodule

// ==== testbench.sv ====
// testbench: register reads and writes over AXI4-Lite against the engine model
`timescale 1ns/10ps
module testbench;
    import autoneg_regs_pkg::*;
    localparam int LIM = 100;
    logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    engine_status_t es, ev, lv;
    engine_control_t ec;
    int num_errors, total_checks;
    autoneg_gigabit_status_regs uut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .engineStatus(es), .engineControl(ec));
    engine_model eng (.clock(clock), .engineControl(ec), .engineStatus(es));
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < LIM);
        bready <= 1'b0;
        if (n >= LIM) begin
            num_errors++;
            close_out();
        end
        check({bresp, 32'h0}, {er, 32'h0});
        @(posedge clock);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < LIM);
        rready <= 1'b0;
        if (n >= LIM) begin
            num_errors++;
            close_out();
        end
        check({rresp, rdata}, {er, 16'h0000, ed});
        @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        logic [15:0] ctl;
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        rdc(OFS_PARTNER_BASE, 16'h0000, RESP_OKAY);
        rdc(OFS_EXPANSION, 16'h0004, RESP_OKAY);
        rdc(OFS_NP_TRANSMIT, 16'h2001, RESP_OKAY);
        rdc(OFS_NP_RECEIVE, 16'h0000, RESP_OKAY);
        rdc(OFS_GIG_CONTROL, 16'h0700, RESP_OKAY);
        rdc(OFS_GIG_STATUS, 16'h4000, RESP_OKAY);
        check({31'h0, ec.portMulti, ec.advGigFdx, ec.advGigHdx}, {31'h0, 3'b111});
        $display("test reset values done");
        rdc(8'h40, 16'h0000, RESP_SLVERR);
        wr(OFS_PARTNER_BASE, 16'hFFFF, RESP_SLVERR);
        rdc(OFS_PARTNER_BASE, 16'h0000, RESP_OKAY);
        $display("test refusals done");
        wr(OFS_NP_TRANSMIT, 16'hFFFF, RESP_OKAY);
        rdc(OFS_NP_TRANSMIT, 16'hB7FF, RESP_OKAY);
        check({18'h0, ec.nextPageWord}, {18'h0, 16'hB7FF});
        check({33'h0, ec.nextPageLoaded}, {33'h0, 1'b1});
        ev = '0;
        ev.pageSent = 1'b1;
        eng.fire(ev);
        check({18'h0, eng.lastSent}, {18'h0, 16'hB7FF});
        rdc(OFS_NP_TRANSMIT, 16'hBFFF, RESP_OKAY);
        check({33'h0, ec.nextPageLoaded}, {33'h0, 1'b0});
        eng.fire(ev);
        check({18'h0, eng.lastSent}, {18'h0, 16'hBFFF});
        rdc(OFS_NP_TRANSMIT, 16'hB7FF, RESP_OKAY);
        $display("test next page transmit done");
        lv = '0;
        lv.partnerAnCapable = 1'b1;
        eng.hold(lv);
        ev = '0;
        ev.basePageValid = 1'b1;
        ev.basePage = 16'hA5E1;
        ev.parallelFault = 1'b1;
        eng.fire(ev);
        rdc(OFS_PARTNER_BASE, 16'hA5E1, RESP_OKAY);
        rdc(OFS_EXPANSION, 16'h001F, RESP_OKAY);
        rdc(OFS_EXPANSION, 16'h000D, RESP_OKAY);
        ev = '0;
        ev.nextPageValid = 1'b1;
        ev.nextPage = 16'h5A5A;
        eng.fire(ev);
        rdc(OFS_NP_RECEIVE, 16'h5A5A, RESP_OKAY);
        rdc(OFS_EXPANSION, 16'h000F, RESP_OKAY);
        $display("test partner pages done");
        lv.localRxOk = 1'b1;
        lv.remoteRxOk = 1'b1;
        eng.hold(lv);
        ev = '0;
        ev.msResolvedValid = 1'b1;
        ev.msFault = 1'b1;
        ev.partnerGigValid = 1'b1;
        ev.partnerGigFdx = 1'b1;
        ev.idleError = 1'b1;
        eng.fire(ev);
        ev = '0;
        ev.idleError = 1'b1;
        eng.fire(ev);
        eng.fire(ev);
        lv.msResolvedMaster = 1'b1;
        eng.hold(lv);
        ev.msResolvedValid = 1'b1;
        eng.fire(ev);
        rdc(OFS_GIG_STATUS, 16'hB804, RESP_OKAY);
        rdc(OFS_GIG_STATUS, 16'h3800, RESP_OKAY);
        ev = '0;
        ev.linkDown = 1'b1;
        eng.fire(ev);
        ev = '0;
        ev.msResolvedValid = 1'b1;
        eng.fire(ev);
        ev.msResolvedValid = 1'b0;
        ev.idleError = 1'b1;
        repeat (300) eng.fire(ev);
        rdc(OFS_GIG_STATUS, 16'h78FF, RESP_OKAY);
        rdc(OFS_GIG_STATUS, 16'h7800, RESP_OKAY);
        $display("test gigabit status done");
        for (int i = 0; i < 8; i++) begin
            ctl = {i[2:0], i[1], i[0], 3'b101, 8'h00};
            wr(OFS_GIG_CONTROL, ctl, RESP_OKAY);
            rdc(OFS_GIG_CONTROL, ctl, RESP_OKAY);
            check({26'h0, ec.testMode, ec.forceMs, ec.forceMaster, ec.portMulti, ec.advGigFdx, ec.advGigHdx},
                {26'h0, (i < 5) ? i[2:0] : TM_NORMAL, i[1], i[0] & i[1], 3'b101});
        end
        $display("test gigabit control done");
        close_out();
    end
endmodule
